// >>> hdl/dppl_pins.sv
// Added by the designer: the AXI4-Lite slave port and the register offsets.
`timescale 1ns/1ps
module dppl_pins
  import dpplpkg::*;
#(
  parameter int  NUM_PINS = 4,
  parameter bit  DUAL_DAC = 1'b1
)(
  input  wire logic                  I_SYS_CLK,
  input  wire logic                  I_RST,
  input  wire logic                  I_CLK_EN,
  input  wire logic [3:0]            I_AWADDR,
  input  wire logic                  I_AWVALID,
  output logic                       O_AWREADY,
  input  wire logic [31:0]           I_WDATA,
  input  wire logic [3:0]            I_WSTRB,
  input  wire logic                  I_WVALID,
  output logic                       O_WREADY,
  output logic [1:0]                 O_BRESP,
  output logic                       O_BVALID,
  input  wire logic                  I_BREADY,
  input  wire logic [3:0]            I_ARADDR,
  input  wire logic                  I_ARVALID,
  output logic                       O_ARREADY,
  output logic [31:0]                O_RDATA,
  output logic [1:0]                 O_RRESP,
  output logic                       O_RVALID,
  input  wire logic                  I_RREADY,
  input  wire logic [NUM_PINS-1:0]   I_PIN,
  output logic [NUM_PINS-1:0]        O_PIN,
  output logic [NUM_PINS-1:0]        O_PIN_OE_N,
  output logic [NUM_PINS-1:0]        O_PULLUP_ON,
  input  wire logic                  I_ADC_DATA_WRITTEN,
  input  wire logic                  I_ADC_DATA_READ,
  output logic                       O_OSC_ENABLE,
  output logic                       O_SLEEP_FORCE,
  output logic                       O_SHUTDOWN_FORCE,
  output logic                       O_LOAD_FIRST_DAC,
  output logic                       O_LOAD_SECOND_DAC,
  output logic                       O_ADC_ACQUIRE,
  output logic                       O_ADC_START,
  output logic                       O_FIRST_DAC_SWITCH_CTL,
  output logic                       O_SECOND_DAC_SWITCH_CTL,
  output logic                       O_OPAMP_TWO_SWITCH_CTL,
  output logic                       O_OPAMP_ONE_SWITCH_CTL,
  output logic                       O_CHANGEOVER_SWITCH_ONE,
  output logic                       O_CHANGEOVER_SWITCH_TWO
);

  logic [NUM_PINS-1:0]   pin_pullup_enable_q;
  logic [NUM_PINS-1:0]   pin_level_bit_q;
  logic [4*NUM_PINS-1:0] pin_function_code_q;
  logic [NUM_PINS-1:0]   sync1_q, sync2_q, prev_q;
  logic [NUM_PINS-1:0]   rise, fall;
  logic [NUM_PINS-1:0]   pin_rise_flag_q, pin_fall_flag_q;
  logic                  data_ready_q, ready_gap_q, acquire_q, oscillator_enable_bit_q;
  logic [NUM_PINS-1:0]   is_output, drive_level;
  logic [3:0]            aw_addr_q;
  logic                  aw_have_q, w_have_q;
  logic [31:0]           w_data_q;
  logic [3:0]            w_strb_q;
  logic                  wr_fire, rd_fire, status_read, osc_clear;
  logic                  load_first, load_second, acq_start, conv_start, wake;
  logic                  sw_a, sw_b, sw_op2, sw_op1, changeover_switch_one, changeover_switch_two;
  logic                  sleep_force, shut_force, rd_ok;
  logic [31:0]           rd_word;

  // Write address and data are accepted independently and held until both are present.
  assign O_AWREADY = !aw_have_q;
  assign O_WREADY  = !w_have_q;
  assign O_ARREADY = !O_RVALID;
  assign wr_fire   = aw_have_q && w_have_q && !O_BVALID;
  assign rd_fire   = I_ARVALID && O_ARREADY && I_CLK_EN;
  assign status_read = rd_fire && (I_ARADDR == DPPL_ADDR_STATUS);
  assign osc_clear = wr_fire && (aw_addr_q == DPPL_ADDR_EVENT) && w_strb_q[0] && w_data_q[DPPL_EV_OSC_CLR];

  always_ff @(posedge I_SYS_CLK)
  begin
    if (I_RST)
    begin
      aw_have_q <= 1'b0;
      w_have_q  <= 1'b0;
      aw_addr_q <= 4'h0;
      w_data_q  <= 32'h0000_0000;
      w_strb_q  <= 4'h0;
      O_BVALID  <= 1'b0;
      O_BRESP   <= AXI_OKAY;
    end
    else if (I_CLK_EN)
    begin
      if (I_AWVALID && O_AWREADY)
      begin
        aw_have_q <= 1'b1;
        aw_addr_q <= I_AWADDR;
      end
      if (I_WVALID && O_WREADY)
      begin
        w_have_q <= 1'b1;
        w_data_q <= I_WDATA;
        w_strb_q <= I_WSTRB;
      end
      if (wr_fire)
      begin
        aw_have_q <= 1'b0;
        w_have_q  <= 1'b0;
        O_BVALID  <= 1'b1;
        O_BRESP   <= (aw_addr_q == DPPL_ADDR_SETUP || aw_addr_q == DPPL_ADDR_CONTROL ||
                      aw_addr_q == DPPL_ADDR_EVENT) ? AXI_OKAY : AXI_SLVERR;
      end
      else if (O_BVALID && I_BREADY)
        O_BVALID <= 1'b0;
    end
  end

  always_ff @(posedge I_SYS_CLK)
  begin
    if (I_RST)
    begin
      pin_pullup_enable_q <= DPPL_PU_RESET;
      pin_level_bit_q     <= DPPL_LL_RESET;
      pin_function_code_q <= DPPL_MODE_RESET;
    end
    else if (I_CLK_EN && wr_fire)
    begin
      if (aw_addr_q == DPPL_ADDR_SETUP && w_strb_q[0])
      begin
        pin_pullup_enable_q <= w_data_q[DPPL_PU_LSB +: NUM_PINS];
        pin_level_bit_q     <= w_data_q[DPPL_LL_LSB +: NUM_PINS];
      end
      if (aw_addr_q == DPPL_ADDR_CONTROL)
      begin
        if (w_strb_q[0])
          pin_function_code_q[7:0] <= w_data_q[7:0];
        if (w_strb_q[1])
          pin_function_code_q[15:8] <= w_data_q[15:8];
      end
    end
  end

  // Pins cross into the clock domain before any edge logic looks at them.
  always_ff @(posedge I_SYS_CLK)
  begin
    if (I_RST)
    begin
      // Idle pins read high through the pull-up, so the history starts high and no false rise follows reset.
      sync1_q <= '1;
      sync2_q <= '1;
      prev_q  <= '1;
    end
    else if (I_CLK_EN)
    begin
      sync1_q <= I_PIN;
      sync2_q <= sync1_q;
      prev_q  <= sync2_q;
    end
  end

  assign rise = sync2_q & ~prev_q;
  assign fall = ~sync2_q & prev_q;

  // A new edge in the cycle of the status read survives the clear.
  always_ff @(posedge I_SYS_CLK)
  begin
    if (I_RST)
    begin
      pin_rise_flag_q <= '0;
      pin_fall_flag_q <= '0;
    end
    else if (I_CLK_EN)
    begin
      pin_rise_flag_q <= (status_read ? '0 : pin_rise_flag_q) | rise;
      pin_fall_flag_q <= (status_read ? '0 : pin_fall_flag_q) | fall;
    end
  end

  always_comb
  begin
    load_first  = 1'b0;
    load_second = 1'b0;
    acq_start   = 1'b0;
    conv_start  = 1'b0;
    wake        = 1'b0;
    sw_a        = 1'b0;
    sw_b        = 1'b0;
    sw_op2      = 1'b0;
    sw_op1      = 1'b0;
    changeover_switch_one       = 1'b0;
    changeover_switch_two       = 1'b0;
    sleep_force = 1'b0;
    shut_force  = 1'b0;
    is_output   = '0;
    drive_level = '0;
    for (int i = 0; i < NUM_PINS; i++)
    begin
      case (pin_function_code_q[4*i +: 4])
        FN_GEN_IN    : ;
        FN_WAKE_FALL : wake = wake | fall[i];
        FN_WAKE_RISE : wake = wake | rise[i];
        FN_SLEEP     : sleep_force = sleep_force | !sync2_q[i];
        FN_SHUTDOWN  : shut_force = shut_force | !sync2_q[i];
        FN_LOAD_BOTH :
        begin
          load_first  = load_first | rise[i];
          load_second = load_second | (rise[i] & DUAL_DAC);
        end
        FN_CONVERSION_START_IN    :
        begin
          acq_start  = acq_start | fall[i];
          conv_start = conv_start | rise[i];
        end
        FN_LOAD_A    : load_first = load_first | rise[i];
        FN_SW_DAC_A  : sw_a = sw_a | sync2_q[i];
        FN_LOAD_B    : load_second = load_second | (rise[i] & DUAL_DAC);
        FN_SW_DAC_B  :
        begin
          sw_b   = sw_b | (sync2_q[i] & DUAL_DAC);
          sw_op2 = sw_op2 | (sync2_q[i] & !DUAL_DAC);
        end
        FN_SW_OPAMP1 : sw_op1 = sw_op1 | sync2_q[i];
        FN_SPDT_ONE  : changeover_switch_one = changeover_switch_one | sync2_q[i];
        FN_SPDT_TWO  : changeover_switch_two = changeover_switch_two | sync2_q[i];
        FN_READY_OUT :
        begin
          is_output[i]   = 1'b1;
          drive_level[i] = data_ready_q & !ready_gap_q;
        end
        FN_GEN_OUT   :
        begin
          is_output[i]   = 1'b1;
          drive_level[i] = pin_level_bit_q[i];
        end
        default      : ;
      endcase
    end
  end

  assign O_PIN       = drive_level;
  assign O_PIN_OE_N  = ~is_output;
  assign O_PULLUP_ON = pin_pullup_enable_q & ~is_output;

  // Ready falls on a data or status read; new data while high makes a one-cycle low gap.
  always_ff @(posedge I_SYS_CLK)
  begin
    if (I_RST)
    begin
      data_ready_q <= 1'b0;
      ready_gap_q  <= 1'b0;
    end
    else if (I_CLK_EN)
    begin
      ready_gap_q <= I_ADC_DATA_WRITTEN && data_ready_q && !(I_ADC_DATA_READ || status_read);
      if (I_ADC_DATA_WRITTEN)
        data_ready_q <= 1'b1;
      else if (I_ADC_DATA_READ || status_read)
        data_ready_q <= 1'b0;
    end
  end

  // One conversion start per low phase, only after acquisition began.
  always_ff @(posedge I_SYS_CLK)
  begin
    if (I_RST)
      acquire_q <= 1'b0;
    else if (I_CLK_EN)
    begin
      if (acq_start)
        acquire_q <= 1'b1;
      else if (conv_start)
        acquire_q <= 1'b0;
    end
  end

  always_ff @(posedge I_SYS_CLK)
  begin
    if (I_RST)
      oscillator_enable_bit_q <= 1'b0;
    else if (I_CLK_EN)
    begin
      if (wake)
        oscillator_enable_bit_q <= 1'b1;
      else if (osc_clear)
        oscillator_enable_bit_q <= 1'b0;
    end
  end

  always_ff @(posedge I_SYS_CLK)
  begin
    if (I_RST)
    begin
      O_LOAD_FIRST_DAC        <= 1'b0;
      O_LOAD_SECOND_DAC       <= 1'b0;
      O_ADC_START             <= 1'b0;
      O_SLEEP_FORCE           <= 1'b0;
      O_SHUTDOWN_FORCE        <= 1'b0;
      O_FIRST_DAC_SWITCH_CTL  <= 1'b0;
      O_SECOND_DAC_SWITCH_CTL <= 1'b0;
      O_OPAMP_TWO_SWITCH_CTL  <= 1'b0;
      O_OPAMP_ONE_SWITCH_CTL  <= 1'b0;
      O_CHANGEOVER_SWITCH_ONE <= 1'b0;
      O_CHANGEOVER_SWITCH_TWO <= 1'b0;
    end
    else if (I_CLK_EN)
    begin
      O_LOAD_FIRST_DAC        <= load_first;
      O_LOAD_SECOND_DAC       <= load_second;
      O_ADC_START             <= conv_start && acquire_q;
      O_SLEEP_FORCE           <= sleep_force;
      O_SHUTDOWN_FORCE        <= shut_force;
      O_FIRST_DAC_SWITCH_CTL  <= sw_a;
      O_SECOND_DAC_SWITCH_CTL <= sw_b;
      O_OPAMP_TWO_SWITCH_CTL  <= sw_op2;
      O_OPAMP_ONE_SWITCH_CTL  <= sw_op1;
      O_CHANGEOVER_SWITCH_ONE <= changeover_switch_one;
      O_CHANGEOVER_SWITCH_TWO <= changeover_switch_two;
    end
  end

  assign O_ADC_ACQUIRE = acquire_q;
  assign O_OSC_ENABLE  = oscillator_enable_bit_q;

  always_comb
  begin
    rd_word = 32'h0000_0000;
    rd_ok   = 1'b1;
    case (I_ARADDR)
      DPPL_ADDR_SETUP   :
      begin
        rd_word[DPPL_PU_LSB +: NUM_PINS] = pin_pullup_enable_q;
        rd_word[DPPL_LL_LSB +: NUM_PINS] = sync2_q;
      end
      DPPL_ADDR_CONTROL : rd_word[4*NUM_PINS-1:0] = pin_function_code_q;
      DPPL_ADDR_STATUS  : rd_word[2*NUM_PINS-1:0] = {pin_rise_flag_q, pin_fall_flag_q};
      DPPL_ADDR_EVENT   :
      begin
        rd_word[DPPL_EV_DATA_BIT] = data_ready_q;
        rd_word[DPPL_EV_OSC_CLR]  = oscillator_enable_bit_q;
      end
      default           : rd_ok = 1'b0;
    endcase
  end

  always_ff @(posedge I_SYS_CLK)
  begin
    if (I_RST)
    begin
      O_RVALID <= 1'b0;
      O_RDATA  <= 32'h0000_0000;
      O_RRESP  <= AXI_OKAY;
    end
    else if (I_CLK_EN)
    begin
      if (rd_fire)
      begin
        O_RVALID <= 1'b1;
        O_RDATA  <= rd_word;
        O_RRESP  <= rd_ok ? AXI_OKAY : AXI_SLVERR;
      end
      else if (O_RVALID && I_RREADY)
        O_RVALID <= 1'b0;
    end
  end

endmodule : dppl_pins

// >>> pkg/dpplpkg.sv
// Notes on behaviour
// - Each pin has a pull-up enable bit, reset 1; 1 connects the pull-up.
// - Pull-up acts only while the pin's function makes it an input.
// - Output-level bit resets 0 and sets the driven level in general output.
// - Reading level bits returns the actual pin levels, in every mode.
// - Code 0000 is general input; its level reads through the level bit.
// - Code 0001: falling edge sets the oscillator enable bit.
// - Code 0010: rising edge sets the oscillator enable bit.
// - Code 0011: low level forces sleep, high returns power control to registers.
// - Code 0100: low level forces shutdown, high returns power control.
// - Code 0101: rising edge loads both DACs, or only the first on single-DAC parts.
// - Code 0110: falling edge starts acquisition, next rising edge starts one conversion.
// - Code 0111: rising edge loads the first DAC.
// - Code 1000: pin level is the first DAC switch control.
// - Code 1001: rising edge loads the second DAC; nothing on single-DAC parts.
// - Code 1010: second DAC switches, or second op amp switches on single-DAC.
// - Code 1011: pin level controls the first op amp switch.
// - Code 1100: pin level controls the first changeover switch.
// - Code 1101: pin level controls the second changeover switch.
// - Code 1110: ready output rises on new data, falls on data or status read.
// - Ready already high drops for one clock when new data arrives.
// - Code 1111: general output following the output-level bit.
// - Four 4-bit function fields in a 16-bit control register, reset 0000.
// - Rise and fall flags per pin; reading the status register clears them.
package dpplpkg;
  localparam logic [3:0]  DPPL_ADDR_SETUP   = 4'h0;
  localparam logic [3:0]  DPPL_ADDR_CONTROL = 4'h4;
  localparam logic [3:0]  DPPL_ADDR_STATUS  = 4'h8;
  localparam logic [3:0]  DPPL_ADDR_EVENT   = 4'hC;
  localparam int          DPPL_PU_LSB       = 4;
  localparam int          DPPL_LL_LSB       = 0;
  localparam int          DPPL_EV_DATA_BIT  = 0;
  localparam int          DPPL_EV_OSC_CLR   = 1;
  localparam int          DPPL_EV_DATA_RD   = 2;
  localparam logic [3:0]  DPPL_PU_RESET     = 4'hF;
  localparam logic [3:0]  DPPL_LL_RESET     = 4'h0;
  localparam logic [15:0] DPPL_MODE_RESET   = 16'h0000;
  localparam logic [3:0]  FN_GEN_IN    = 4'h0;
  localparam logic [3:0]  FN_WAKE_FALL = 4'h1;
  localparam logic [3:0]  FN_WAKE_RISE = 4'h2;
  localparam logic [3:0]  FN_SLEEP     = 4'h3;
  localparam logic [3:0]  FN_SHUTDOWN  = 4'h4;
  localparam logic [3:0]  FN_LOAD_BOTH = 4'h5;
  localparam logic [3:0]  FN_CONVERSION_START_IN    = 4'h6;
  localparam logic [3:0]  FN_LOAD_A    = 4'h7;
  localparam logic [3:0]  FN_SW_DAC_A  = 4'h8;
  localparam logic [3:0]  FN_LOAD_B    = 4'h9;
  localparam logic [3:0]  FN_SW_DAC_B  = 4'hA;
  localparam logic [3:0]  FN_SW_OPAMP1 = 4'hB;
  localparam logic [3:0]  FN_SPDT_ONE  = 4'hC;
  localparam logic [3:0]  FN_SPDT_TWO  = 4'hD;
  localparam logic [3:0]  FN_READY_OUT = 4'hE;
  localparam logic [3:0]  FN_GEN_OUT   = 4'hF;
  localparam logic [1:0]  AXI_OKAY     = 2'h0;
  localparam logic [1:0]  AXI_SLVERR   = 2'h2;
endpackage : dpplpkg

// >>> tb/dppl_props.sv
`timescale 1ns/1ps
module dppl_props
  import dpplpkg::*;
#(
  parameter int NUM_PINS = 4
)(
  input wire logic                I_SYS_CLK,
  input wire logic                I_RST,
  input wire logic                I_ARVALID,
  input wire logic                O_ARREADY,
  input wire logic                O_RVALID,
  input wire logic [NUM_PINS-1:0] I_PIN,
  input wire logic [NUM_PINS-1:0] O_PIN_OE_N,
  input wire logic [NUM_PINS-1:0] O_PULLUP_ON,
  input wire logic                O_OSC_ENABLE,
  input wire logic                O_SLEEP_FORCE,
  input wire logic                O_SHUTDOWN_FORCE,
  input wire logic                O_LOAD_FIRST_DAC,
  input wire logic                O_LOAD_SECOND_DAC,
  input wire logic                O_ADC_ACQUIRE,
  input wire logic                O_ADC_START
);
  logic [NUM_PINS-1:0] h_q [0:5];
  logic                rise_any;
  logic                fall_any;
  logic                all_high;
  // Pin history lets each event be traced back to an edge on some pin.
  always_ff @(posedge I_SYS_CLK)
  begin
    h_q[0] <= I_PIN;
    for (int k = 1; k < 6; k++)
    begin
      h_q[k] <= h_q[k-1];
    end
  end
  assign rise_any = |(h_q[0] & ~h_q[5]);
  assign fall_any = |(~h_q[0] & h_q[5]);
  assign all_high = &{h_q[1], h_q[2], h_q[3], h_q[4]};
  default clocking cb @(posedge I_SYS_CLK);
  endclocking
  default disable iff (I_RST);
  sequence s_rise_pulse(x);
    x && rise_any ##1 !x;
  endsequence
  property p_pullup_input;
    (O_PULLUP_ON & ~O_PIN_OE_N) == '0;
  endproperty
  property p_wake;
    $rose(O_OSC_ENABLE) |-> rise_any || fall_any;
  endproperty
  property p_power;
    all_high |-> !O_SLEEP_FORCE && !O_SHUTDOWN_FORCE;
  endproperty
  property p_load_first;
    O_LOAD_FIRST_DAC |-> s_rise_pulse(O_LOAD_FIRST_DAC);
  endproperty
  property p_load_second;
    O_LOAD_SECOND_DAC |-> s_rise_pulse(O_LOAD_SECOND_DAC);
  endproperty
  property p_acquire;
    $rose(O_ADC_ACQUIRE) |-> fall_any;
  endproperty
  property p_start;
    O_ADC_START |-> $past(O_ADC_ACQUIRE) ##0 s_rise_pulse(O_ADC_START);
  endproperty
  property p_read;
    I_ARVALID && O_ARREADY |=> O_RVALID;
  endproperty
  property p_refuse;
    O_RVALID |-> !O_ARREADY;
  endproperty
  a_pullup_input: assert property (p_pullup_input)
    else $error("pull-up on at a driven pin");
  a_wake: assert property (p_wake)
    else $error("oscillator on without a pin edge");
  a_power: assert property (p_power)
    else $error("power override with all pins high");
  a_load_first: assert property (p_load_first)
    else $error("bad first load pulse");
  a_load_second: assert property (p_load_second)
    else $error("bad second load pulse");
  a_acquire: assert property (p_acquire)
    else $error("acquire without a falling pin");
  a_start: assert property (p_start)
    else $error("bad conversion start");
  a_read: assert property (p_read)
    else $error("no read answer");
  a_refuse: assert property (p_refuse)
    else $error("read taken while answer pending");
endmodule : dppl_props
bind dppl_pins dppl_props #(.NUM_PINS(NUM_PINS)) dppl_props_i (
  .I_SYS_CLK(I_SYS_CLK), .I_RST(I_RST), .I_ARVALID(I_ARVALID), .O_ARREADY(O_ARREADY),
  .O_RVALID(O_RVALID), .I_PIN(I_PIN), .O_PIN_OE_N(O_PIN_OE_N), .O_PULLUP_ON(O_PULLUP_ON),
  .O_OSC_ENABLE(O_OSC_ENABLE), .O_SLEEP_FORCE(O_SLEEP_FORCE), .O_SHUTDOWN_FORCE(O_SHUTDOWN_FORCE),
  .O_LOAD_FIRST_DAC(O_LOAD_FIRST_DAC), .O_LOAD_SECOND_DAC(O_LOAD_SECOND_DAC),
  .O_ADC_ACQUIRE(O_ADC_ACQUIRE), .O_ADC_START(O_ADC_START)
);

// >>> tb/dppl_partner.sv
`timescale 1ns/1ps
module dppl_partner (
  input  wire logic       i_clk,
  input  wire logic [3:0] i_drv_en,
  input  wire logic [3:0] i_drv_val,
  input  wire logic [3:0] i_out,
  input  wire logic [3:0] i_oe_n,
  input  wire logic [3:0] i_pu,
  output logic [3:0]      o_lvl
);
  logic [3:0] last_q;
  // A floating line flips every cycle so that it never reads as a stable level.
  always_comb
  begin
    for (int k = 0; k < 4; k++)
    begin
      if (!i_oe_n[k])
        o_lvl[k] = i_out[k];
      else if (i_drv_en[k])
        o_lvl[k] = i_drv_val[k];
      else if (i_pu[k])
        o_lvl[k] = 1'b1;
      else
        o_lvl[k] = ~last_q[k];
    end
  end
  always_ff @(posedge i_clk)
  begin
    last_q <= o_lvl;
  end
endmodule : dppl_partner

// >>> tb/digital_programmable_pin_logic_test.sv
`timescale 1ns/1ps
module digital_programmable_pin_logic_test
  import dpplpkg::*;
;
  logic        clk, rst, awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready;
  logic        rvalid, rready, dwr, drd, osc, sleep_override_in, shd, lfa, lsa, acq, st;
  logic [1:0]  bresp, rresp, rsp;
  logic [3:0]  awaddr, araddr, pin_in, pin_out, oe_n, pu, drv_en, drv_val;
  logic [5:0]  swv;
  logic [31:0] wdata, rdata, rv;
  int          errors = 0, n_checks = 0, cyc = 0, n_la = 0, n_lb = 0, n_st = 0, n_lo = 0;
  dppl_pins #(.NUM_PINS(4), .DUAL_DAC(1'b1)) dppl_pins_i (
    .I_SYS_CLK(clk), .I_RST(rst), .I_CLK_EN(1'b1), .I_AWADDR(awaddr), .I_AWVALID(awvalid),
    .O_AWREADY(awready), .I_WDATA(wdata), .I_WSTRB(4'hF), .I_WVALID(wvalid), .O_WREADY(wready),
    .O_BRESP(bresp), .O_BVALID(bvalid), .I_BREADY(bready), .I_ARADDR(araddr), .I_ARVALID(arvalid),
    .O_ARREADY(arready), .O_RDATA(rdata), .O_RRESP(rresp), .O_RVALID(rvalid), .I_RREADY(rready),
    .I_PIN(pin_in), .O_PIN(pin_out), .O_PIN_OE_N(oe_n), .O_PULLUP_ON(pu), .I_ADC_DATA_WRITTEN(dwr),
    .I_ADC_DATA_READ(drd), .O_OSC_ENABLE(osc), .O_SLEEP_FORCE(sleep_override_in), .O_SHUTDOWN_FORCE(shd),
    .O_LOAD_FIRST_DAC(lfa), .O_LOAD_SECOND_DAC(lsa), .O_ADC_ACQUIRE(acq), .O_ADC_START(st),
    .O_FIRST_DAC_SWITCH_CTL(swv[5]), .O_SECOND_DAC_SWITCH_CTL(swv[4]), .O_OPAMP_ONE_SWITCH_CTL(swv[3]),
    .O_CHANGEOVER_SWITCH_ONE(swv[2]), .O_CHANGEOVER_SWITCH_TWO(swv[1]), .O_OPAMP_TWO_SWITCH_CTL(swv[0])
  );
  dppl_partner dppl_partner_i (.i_clk(clk), .i_drv_en(drv_en), .i_drv_val(drv_val), .i_out(pin_out),
    .i_oe_n(oe_n), .i_pu(pu), .o_lvl(pin_in));
  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // Counting on the falling edge keeps one-cycle pulses clear of the launching edge.
  always @(negedge clk)
  begin
    if (lfa !== 1'b0) n_la++;
    if (lsa !== 1'b0) n_lb++;
    if (st !== 1'b0) n_st++;
    if (pin_out[0] !== 1'b1) n_lo++;
    cyc++;
    if (cyc > 20000)
    begin
      errors++;
      conclude();
    end
  end
  task automatic conclude();
    begin
      $display("checks %0d errors %0d", n_checks, errors);
      if (errors == 0 && n_checks > 0)
        $display("== PASSED ==");
      else
        $display("== FAILED ==");
      $finish;
    end
  endtask : conclude
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    begin
      n_checks++;
      if (g !== e)
      begin
        errors++;
        $display("BAD at %0t got %h exp %h", $time, g, e);
      end
    end
  endtask : chk
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    logic av, dv, arv, fin;
    begin
      @(posedge clk);
      awaddr <= a;
      araddr <= a;
      wdata <= d;
      awvalid <= w;
      wvalid <= w;
      bready <= w;
      arvalid <= !w;
      rready <= !w;
      fin = 1'b0;
      while (!fin)
      begin
        @(negedge clk);
        av = awvalid && awready;
        dv = wvalid && wready;
        arv = arvalid && arready;
        fin = (bvalid && bready) || (rvalid && rready);
        rv = rdata;
        rsp = w ? bresp : rresp;
        @(posedge clk);
        if (av) awvalid <= 1'b0;
        if (dv) wvalid <= 1'b0;
        if (arv) arvalid <= 1'b0;
      end
      bready <= 1'b0;
      rready <= 1'b0;
      chk(32'(rsp), 32'(AXI_OKAY));
    end
  endtask : bus
  task automatic rd(input logic [3:0] a, input logic [31:0] e);
    begin
      bus(1'b0, a, 32'h0);
      chk(rv, e);
    end
  endtask : rd
  task automatic pin(input int k, input logic en, input logic v);
    begin
      @(posedge clk);
      drv_en[k] <= en;
      drv_val[k] <= v;
      repeat (8) @(posedge clk);
    end
  endtask : pin
  task automatic t_setup();
    begin
      chk(32'({pu, oe_n}), 32'hFF);
      rd(DPPL_ADDR_SETUP, 32'hFF);
      rd(DPPL_ADDR_CONTROL, 32'h0);
      bus(1'b1, DPPL_ADDR_CONTROL, 32'hFFFF);
      bus(1'b1, DPPL_ADDR_SETUP, 32'hF5);
      repeat (4) @(posedge clk);
      chk(32'({pu, oe_n, pin_out}), 32'h005);
      rd(DPPL_ADDR_SETUP, 32'hF5);
      bus(1'b1, DPPL_ADDR_SETUP, 32'h50);
      bus(1'b1, DPPL_ADDR_CONTROL, 32'h0);
      chk(32'(pu), 32'h5);
      bus(1'b1, DPPL_ADDR_SETUP, 32'hF0);
      @(posedge clk);
      drv_en <= 4'hF;
      drv_val <= 4'h6;
      repeat (8) @(posedge clk);
      rd(DPPL_ADDR_SETUP, 32'hF6);
      drv_en <= 4'h0;
    end
  endtask : t_setup
  task automatic t_wake_power();
    begin
      bus(1'b1, DPPL_ADDR_CONTROL, 32'h4321);
      pin(0, 1'b1, 1'b0);
      rd(DPPL_ADDR_EVENT, 32'h2);
      bus(1'b1, DPPL_ADDR_EVENT, 32'h2);
      pin(0, 1'b0, 1'b0);
      pin(1, 1'b1, 1'b0);
      chk(32'(osc), 32'h0);
      pin(1, 1'b0, 1'b0);
      chk(32'(osc), 32'h1);
      pin(2, 1'b1, 1'b0);
      chk(32'({sleep_override_in, shd}), 32'h2);
      pin(2, 1'b0, 1'b0);
      pin(3, 1'b1, 1'b0);
      chk(32'({sleep_override_in, shd}), 32'h1);
      pin(3, 1'b0, 1'b0);
      chk(32'({sleep_override_in, shd}), 32'h0);
    end
  endtask : t_wake_power
  task automatic t_strobes();
    logic [3:0] code [3];
    int         ea [3];
    int         eb [3];
    begin
      code = '{FN_LOAD_BOTH, FN_LOAD_A, FN_LOAD_B};
      ea = '{1, 1, 0};
      eb = '{1, 0, 1};
      for (int i = 0; i < 3; i++)
      begin
        bus(1'b1, DPPL_ADDR_CONTROL, {28'h0, code[i]});
        n_la = 0;
        n_lb = 0;
        pin(0, 1'b1, 1'b0);
        pin(0, 1'b0, 1'b0);
        chk(n_la, ea[i]);
        chk(n_lb, eb[i]);
      end
      bus(1'b1, DPPL_ADDR_CONTROL, {28'h0, FN_CONVERSION_START_IN});
      n_st = 0;
      pin(0, 1'b1, 1'b0);
      chk(32'(acq), 32'h1);
      chk(n_st, 0);
      pin(0, 1'b0, 1'b0);
      chk(n_st, 1);
    end
  endtask : t_strobes
  task automatic t_switch();
    logic [3:0] code [5];
    begin
      code = '{FN_SW_DAC_A, FN_SW_DAC_B, FN_SW_OPAMP1, FN_SPDT_ONE, FN_SPDT_TWO};
      for (int i = 0; i < 5; i++)
      begin
        bus(1'b1, DPPL_ADDR_CONTROL, {28'h0, code[i]});
        pin(0, 1'b0, 1'b0);
        chk(32'(swv), 32'h20 >> i);
        pin(0, 1'b1, 1'b0);
        chk(32'(swv), 32'h0);
      end
      pin(0, 1'b0, 1'b0);
    end
  endtask : t_switch
  task automatic t_ready();
    begin
      bus(1'b1, DPPL_ADDR_CONTROL, {28'h0, FN_READY_OUT});
      for (int i = 0; i < 3; i++)
      begin
        @(posedge clk);
        dwr <= 1'b1;
        @(posedge clk);
        dwr <= 1'b0;
        n_lo = 0;
        repeat (6) @(posedge clk);
        chk(32'({oe_n[0], pin_out[0]}), 32'h1);
        chk(n_lo, i == 1);
        if (i == 1)
          bus(1'b0, DPPL_ADDR_STATUS, 32'h0);
        else if (i == 2)
        begin
          @(posedge clk);
          drd <= 1'b1;
          @(posedge clk);
          drd <= 1'b0;
          repeat (4) @(posedge clk);
        end
        if (i > 0)
          chk(32'(pin_out[0]), 32'h0);
      end
    end
  endtask : t_ready
  task automatic t_status();
    begin
      bus(1'b1, DPPL_ADDR_CONTROL, 32'h0);
      repeat (8) @(posedge clk);
      bus(1'b0, DPPL_ADDR_STATUS, 32'h0);
      pin(3, 1'b1, 1'b0);
      pin(3, 1'b0, 1'b0);
      rd(DPPL_ADDR_STATUS, 32'h88);
      rd(DPPL_ADDR_STATUS, 32'h0);
    end
  endtask : t_status
  initial
  begin
    rst = 1'b1;
    {awvalid, wvalid, bready, arvalid, rready, dwr, drd} = '0;
    {awaddr, araddr, wdata, drv_en, drv_val} = '0;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    repeat (4) @(posedge clk);
    t_setup();
    t_wake_power();
    t_strobes();
    t_switch();
    t_ready();
    t_status();
    conclude();
  end
endmodule : digital_programmable_pin_logic_test
